/* mps_defines.svh */
// mps_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and from the modules
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

// ----------------------------------------------------------------
// module management map (word index on the two-wire side)
// ----------------------------------------------------------------
`define MPS_ADDR_W 4
`define MPS_MA_STATE 4'h0
`define MPS_MA_FLAGS 4'h1
`define MPS_MA_CONTROL 4'h2
`define MPS_MA_DEINIT 4'h3
`define MPS_MA_TXDIS 4'h4
`define MPS_MA_SQUELCH 4'h5
`define MPS_MA_POWER 4'h6
`define MPS_MA_FLAGMASK 4'h7
`define MPS_MA_PATHSTATE 4'h8
// control field positions
`define MPS_CTL_SW_LP 0
`define MPS_CTL_ALLOW_HW 1
// power-on defaults and fixed power class
`define MPS_CONTROL_RST 8'h02
`define MPS_DEINIT_RST 8'h00
`define MPS_TXDIS_RST 8'h00
`define MPS_SQUELCH_RST 8'h00
`define MPS_POWER_CLASS 8'h05
`define MPS_DEFAULT_CFG 8'h11

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MPS_CLK_NS 50
`define MPS_INIT_NS 1000
`define MPS_PWRUP_NS 2000
`define MPS_INIT_CYC (`MPS_INIT_NS / `MPS_CLK_NS)
`define MPS_PWRUP_CYC (`MPS_PWRUP_NS / `MPS_CLK_NS)

// ----------------------------------------------------------------
// host controller registers (AHB-Lite byte offsets)
// ----------------------------------------------------------------
`define MPS_H_CTRL 8'h00
`define MPS_H_STATUS 8'h04
`define MPS_H_ISTAT 8'h08
`define MPS_H_IMASK 8'h0C
`define MPS_H_POWER 8'h10
// host control bits
`define MPS_HC_START 0
`define MPS_HC_HWLP_EN 1
// host interrupt bits
`define MPS_HI_LOWPWR 0
`define MPS_HI_READY 1
`define MPS_HI_FAULT 2

`endif

/* mps_event_flag.sv */
// mps_event_flag.sv: sticky flag with set-over-clear
// assumes: set and clear are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module mps_event_flag (
  input wire logic clock,
  input wire logic reset,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  // set wins so an event in the clearing cycle is kept
  always_ff @(posedge clock) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : mps_event_flag
`default_nettype wire

/* mps_host.sv */
// mps_host.sv: host end, power-up sequence driven from AHB-Lite registers
// assumes: module end on the host modport; one AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"
module mps_host
  import mps_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  mps_link_if.host link
);
  typedef enum logic [3:0] {
    h_idle, h_wait_int, h_rd_flags, h_rd_power, h_wr_deinit,
    h_wr_txdis, h_wr_ctrl, h_wait_ready, h_rd_flags2, h_done
  } mps_host_state_t;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  mps_host_state_t hstate;
  logic [7:0] ctrl;
  logic [2:0] istat;
  logic [2:0] imask;
  mps_byte_t power_need;
  logic ph_wr;
  logic ph_rd;
  logic [7:0] ph_addr;
  logic [2:0] ev;

  // zero-wait slave; address phase latched for the data phase
  always_ff @(posedge clock) begin
    if (reset) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_rd <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr[7:0];
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= 8'h00;
      imask <= 3'h0;
    end else if (ph_wr) begin
      if (ph_addr == `MPS_H_CTRL) ctrl <= hwdata[7:0];
      if (ph_addr == `MPS_H_IMASK) imask <= hwdata[2:0];
    end else begin
      ctrl[`MPS_HC_START] <= 1'b0; // start is a self-clearing pulse
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      istat <= 3'h0;
    end else begin
      istat <= (istat & ~((ph_wr && ph_addr == `MPS_H_ISTAT) ?
                hwdata[2:0] : 3'h0)) | ev;
    end
  end
  assign irq = |(istat & imask);

  // combinational read mux, data stands in the data phase
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_rd) begin
      unique case (ph_addr)
        `MPS_H_CTRL: hrdata = {24'h00_0000, ctrl};
        `MPS_H_STATUS: hrdata = {28'h000_0000, hstate};
        `MPS_H_ISTAT: hrdata = {29'h0000_0000, istat};
        `MPS_H_IMASK: hrdata = {29'h0000_0000, imask};
        `MPS_H_POWER: hrdata = {24'h00_0000, power_need};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequence engine
  // ----------------------------------------------------------------
  // pins held per power-up preconditions
  assign link.module_select = 1'b1;
  assign link.module_reset = reset;
  always_ff @(posedge clock) begin
    if (reset) begin
      link.hw_low_power_request <= 1'b1;
    end else if (hstate == h_done && !ctrl[`MPS_HC_HWLP_EN]) begin
      link.hw_low_power_request <= 1'b0;
    end
  end

  // one access per state; ack returns in the request cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      hstate <= h_idle;
      power_need <= 8'h00;
      ev <= 3'h0;
    end else begin
      ev <= 3'h0;
      unique case (hstate)
        h_idle:
          if (ctrl[`MPS_HC_START] && link.present) hstate <= h_wait_int;
        h_wait_int:
          if (!link.int_n) hstate <= h_rd_flags;
        h_rd_flags:
          if (link.ack) hstate <= h_rd_power;
        h_rd_power: begin
          if (link.ack) begin
            hstate <= h_wr_deinit;
            ev[`MPS_HI_LOWPWR] <= 1'b1;
          end
        end
        h_wr_deinit:
          if (link.ack) hstate <= h_wr_txdis;
        h_wr_txdis:
          if (link.ack) hstate <= h_wr_ctrl;
        h_wr_ctrl:
          if (link.ack) hstate <= h_wait_ready;
        h_wait_ready:
          if (!link.int_n) hstate <= h_rd_flags2;
        h_rd_flags2: begin
          if (link.ack) begin
            hstate <= h_done;
            ev[`MPS_HI_READY] <= 1'b1;
          end
        end
        h_done:
          if (ctrl[`MPS_HC_START]) hstate <= h_wait_int;
        default: begin
          hstate <= h_idle;
          ev[`MPS_HI_FAULT] <= 1'b1;
        end
      endcase
      // power read data arrives one cycle after the request
      if (hstate == h_wr_deinit) power_need <= link.rdata;
    end
  end

  // request drive decoded from state
  always_comb begin
    link.req = 1'b1;
    link.we = 1'b0;
    link.addr = `MPS_MA_FLAGS;
    link.wdata = 8'h00;
    unique case (hstate)
      h_rd_flags, h_rd_flags2: link.addr = `MPS_MA_FLAGS;
      h_rd_power: link.addr = `MPS_MA_POWER;
      h_wr_deinit: begin
        link.we = 1'b1;
        link.addr = `MPS_MA_DEINIT;
        link.wdata = 8'hFF;
      end
      h_wr_txdis: begin
        link.we = 1'b1;
        link.addr = `MPS_MA_TXDIS;
        link.wdata = 8'hFF;
      end
      h_wr_ctrl: begin
        link.we = 1'b1;
        link.addr = `MPS_MA_CONTROL;
        link.wdata = 8'h00;
      end
      default: link.req = 1'b0;
    endcase
  end
endmodule : mps_host
`default_nettype wire

/* mps_link_if.sv */
// mps_link_if.sv: host-to-module management link
// assumes: single clock; simple register access abstracts the two-wire bus
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"
interface mps_link_if
  import mps_pkg::*;
(
  input wire logic clock
);
  logic present;
  logic hw_low_power_request;
  logic module_select;
  logic module_reset;
  logic int_n;
  logic req;
  logic we;
  logic [`MPS_ADDR_W-1:0] addr;
  mps_byte_t wdata;
  mps_byte_t rdata;
  logic ack;

  modport host (
    input present, int_n, rdata, ack,
    output hw_low_power_request, module_select, module_reset,
    output req, we, addr, wdata
  );
  modport dev (
    output present, int_n, rdata, ack,
    input hw_low_power_request, module_select, module_reset,
    input req, we, addr, wdata
  );
endinterface : mps_link_if
`default_nettype wire

/* mps_link_props.sv */
// mps_link_props.sv: timing and order checks on the host-module link
// assumes: instantiated beside the link interface, one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"
module mps_link_props
  import mps_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic present,
  input wire logic hw_low_power_request,
  input wire logic module_select,
  input wire logic module_reset,
  input wire logic int_n,
  input wire logic req,
  input wire logic we,
  input wire logic [`MPS_ADDR_W-1:0] addr,
  input wire mps_byte_t wdata,
  input wire mps_byte_t rdata,
  input wire logic ack
);
  // ----------------------------------------------------------------
  // history of host actions and module interrupts since reset
  // ----------------------------------------------------------------
  logic seen_int;
  logic deinit_ff;
  logic txdis_ff;
  logic pwr_rd;
  logic wr_ctl;
  logic rd_flags;
  assign wr_ctl = req && we && addr == `MPS_MA_CONTROL;
  assign rd_flags = req && !we && addr == `MPS_MA_FLAGS;

  // sticky bits, so order checks need no unbounded sequences
  always_ff @(posedge clock) begin
    if (reset) begin
      seen_int <= 1'b0;
      deinit_ff <= 1'b0;
      txdis_ff <= 1'b0;
      pwr_rd <= 1'b0;
    end else begin
      if (!int_n) seen_int <= 1'b1;
      if (req && we && addr == `MPS_MA_DEINIT && wdata == 8'hFF)
        deinit_ff <= 1'b1;
      if (req && we && addr == `MPS_MA_TXDIS && wdata == 8'hFF)
        txdis_ff <= 1'b1;
      if (req && !we && addr == `MPS_MA_POWER) pwr_rd <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);

  // init window is 20 cycles; slack of a few for entry latency
  init_flag_a: assert property (
      $fell(reset) |-> int_n [*8] ##[10:16] !int_n)
    else $error("low-power entry interrupt out of window");
  flag_clear_a: assert property (rd_flags |-> ##[1:3] int_n)
    else $error("flag read did not drop interrupt");
  // a pending interrupt means the latched flag must read back as one
  flag_data_a: assert property (
      ack && rd_flags && !int_n |=> rdata == 8'h01)
    else $error("flag read did not return the latched flag");
  pwrup_time_a: assert property (
      wr_ctl && !wdata[`MPS_CTL_ALLOW_HW] && !wdata[`MPS_CTL_SW_LP]
      |-> ##1 int_n [*8] ##[28:36] !int_n)
    else $error("ready interrupt out of power-up window");
  reset_pass_a: assert property (!module_reset)
    else $error("module reset held outside host reset");
  select_high_a: assert property (present && module_select)
    else $error("module not present or not selected");
  early_access_a: assert property (req |-> seen_int || !int_n)
    else $error("link access before first interrupt");
  cfg_order_a: assert property (
      wr_ctl && !wdata[`MPS_CTL_ALLOW_HW] |-> deinit_ff && txdis_ff && pwr_rd)
    else $error("allow bit cleared before setup was done");
  power_data_a: assert property (
      req && !we && addr == `MPS_MA_POWER |=> rdata == `MPS_POWER_CLASS)
    else $error("power class read wrong");
  hw_request_a: assert property (
      $fell(reset) |-> hw_low_power_request [*8])
    else $error("hardware low-power request not held after reset");

  cover property (rd_flags);
  cover property (wr_ctl && !wdata[`MPS_CTL_ALLOW_HW]);
  cover property (req && !we && addr == `MPS_MA_POWER);
endmodule : mps_link_props
`default_nettype wire

/* mps_module.sv */
// mps_module.sv: module end, management state sequencer and flag logic
// assumes: host end on the dev modport; reset is host hardware reset
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"
// Behaviour
// - host powers, asserts low-power request, deasserts reset
// - management init loads control defaults
// - default config into active and staged set
// - low-power entry sets state-changed flag
// - flag register read drops interrupt
// - host waits interrupt before configuring
// - host reads power needs in low power
// - host writes FFh to deinit mask
// - ready starts init of unmasked paths
// - host writes FFh to tx disable
// - tx disable bit blocks path activation
// - host clears allow bit for high power
// - host disables hardware low-power request
// - low-power condition false enters power-up
// - power-up keeps all paths deactivated
// - ready entry sets state-changed flag again
// - host waits interrupt after clearing allow
module mps_module
  import mps_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  mps_link_if.dev link,
  output mps_mod_state_t module_state,
  output logic tx_enable
);
  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] control;
  mps_byte_t path_deinit_mask;
  mps_byte_t tx_output_disable;
  mps_byte_t tx_force_squelch;
  mps_byte_t flag_mask;
  mps_byte_t active_cfg;
  mps_byte_t staged_cfg0;
  mps_path_state_t path_state;
  logic [15:0] timer;
  logic state_change_flag;
  logic low_power_condition;
  logic wr;
  logic rd;
  logic enter_event;
  logic flag_read;
  mps_mod_state_t next_state;

  assign wr = link.req && link.we && !link.module_reset;
  assign rd = link.req && !link.we && !link.module_reset;
  assign link.present = 1'b1;
  assign link.ack = link.req;

  // effective low-power transition condition
  assign low_power_condition = control[`MPS_CTL_SW_LP] ||
    (control[`MPS_CTL_ALLOW_HW] && link.hw_low_power_request);

  // writable controls; defaults loaded while in management init
  always_ff @(posedge clock) begin
    if (reset || link.module_reset ||
        module_state == mgmt_init_state) begin
      control <= `MPS_CONTROL_RST;
      path_deinit_mask <= `MPS_DEINIT_RST;
      tx_output_disable <= `MPS_TXDIS_RST;
      tx_force_squelch <= `MPS_SQUELCH_RST;
      flag_mask <= 8'h00;
    end else if (wr) begin
      unique case (link.addr)
        `MPS_MA_CONTROL: control <= link.wdata;
        `MPS_MA_DEINIT: path_deinit_mask <= link.wdata;
        `MPS_MA_TXDIS: tx_output_disable <= link.wdata;
        `MPS_MA_SQUELCH: tx_force_squelch <= link.wdata;
        `MPS_MA_FLAGMASK: flag_mask <= link.wdata;
        default: ;
      endcase
    end
  end

  // default data path configuration, both control sets
  always_ff @(posedge clock) begin
    if (reset || link.module_reset ||
        module_state == mgmt_init_state) begin
      active_cfg <= `MPS_DEFAULT_CFG;
      staged_cfg0 <= `MPS_DEFAULT_CFG;
    end
  end

  // ----------------------------------------------------------------
  // module state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = module_state;
    unique case (module_state)
      mgmt_init_state:
        if (timer == 16'h0000) next_state = low_power_state;
      low_power_state:
        if (!low_power_condition) next_state = powering_up_state;
      powering_up_state:
        if (low_power_condition) next_state = low_power_state;
        else if (timer == 16'h0000) next_state = ready_state;
      ready_state:
        if (low_power_condition) next_state = low_power_state;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset || link.module_reset) begin
      module_state <= mgmt_init_state;
    end else begin
      module_state <= next_state;
    end
  end

  // init and power-up dwell times as a down counter
  always_ff @(posedge clock) begin
    if (reset || link.module_reset) begin
      timer <= 16'(`MPS_INIT_CYC - 1);
    end else if (next_state != module_state &&
                 next_state == powering_up_state) begin
      timer <= 16'(`MPS_PWRUP_CYC - 1);
    end else if (timer != 16'h0000) begin
      timer <= timer - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // data path: one aggregate path over all lanes
  // ----------------------------------------------------------------
  // path leaves deactivation only in ready; elsewhere forced down
  always_ff @(posedge clock) begin
    if (reset || link.module_reset || module_state != ready_state) begin
      path_state <= path_deactivated;
    end else begin
      unique case (path_state)
        path_deactivated:
          if (path_deinit_mask != 8'hFF) path_state <= path_init;
        path_init:
          path_state <= path_initialized;
        path_initialized:
          if (tx_output_disable == 8'h00) begin
            path_state <= path_activated;
          end
        path_activated:
          if (path_deinit_mask == 8'hFF) path_state <= path_deactivated;
      endcase
    end
  end

  // tx lanes live only when activated, not disabled, not squelched
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_enable <= 1'b0;
    end else begin
      tx_enable <= path_state == path_activated &&
                   tx_output_disable == 8'h00 &&
                   tx_force_squelch == 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // state-changed flag and interrupt
  // ----------------------------------------------------------------
  assign enter_event = next_state != module_state &&
    (next_state == low_power_state || next_state == ready_state);
  assign flag_read = rd && link.addr == `MPS_MA_FLAGS;

  mps_event_flag u_state_flag (
    .clock(clock),
    .reset(reset || link.module_reset),
    .set(enter_event),
    .clear(flag_read),
    .flag(state_change_flag)
  );

  // interrupt active low while unmasked flag is latched
  assign link.int_n = !(state_change_flag && !flag_mask[0]);

  // read data registered; reading flags clears them
  always_ff @(posedge clock) begin
    if (reset) begin
      link.rdata <= 8'h00;
    end else if (rd) begin
      unique case (link.addr)
        `MPS_MA_STATE: link.rdata <= {6'h00, module_state};
        `MPS_MA_FLAGS: link.rdata <= {7'h00, state_change_flag};
        `MPS_MA_CONTROL: link.rdata <= control;
        `MPS_MA_DEINIT: link.rdata <= path_deinit_mask;
        `MPS_MA_TXDIS: link.rdata <= tx_output_disable;
        `MPS_MA_SQUELCH: link.rdata <= tx_force_squelch;
        `MPS_MA_POWER: link.rdata <= `MPS_POWER_CLASS;
        `MPS_MA_FLAGMASK: link.rdata <= flag_mask;
        `MPS_MA_PATHSTATE: link.rdata <= {6'h00, path_state};
        default: link.rdata <= active_cfg ^ staged_cfg0;
      endcase
    end
  end
endmodule : mps_module
`default_nettype wire

/* mps_pkg.sv */
// mps_pkg.sv: types shared by both ends of the power-up link
// assumes: mps_defines.svh holds the numbers
`include "mps_defines.svh"
package mps_pkg;
  // module management states
  typedef enum logic [1:0] {
    mgmt_init_state,
    low_power_state,
    powering_up_state,
    ready_state
  } mps_mod_state_t;

  // data path states
  typedef enum logic [1:0] {
    path_deactivated,
    path_init,
    path_initialized,
    path_activated
  } mps_path_state_t;

  typedef logic [7:0] mps_byte_t;
endpackage : mps_pkg

/* tb_module_power_up_sequencer.sv */
// tb_module_power_up_sequencer.sv: both link ends driven over AHB-Lite
// assumes: one slave on the bus, so hready is the slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "mps_defines.svh"
module tb_module_power_up_sequencer
  import mps_pkg::*;
;
  logic clock, reset, hsel, hwrite, dp_rd, saw_pu;
  logic [31:0] haddr, hwdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, tx_enable;
  mps_mod_state_t module_state;
  int n_errors, checks_done, cycles, run;
  assign hready = hreadyout;

  // ----------------------------------------------------------------
  // design and checker
  // ----------------------------------------------------------------
  mps_link_if mps_link_if_i (.clock(clock));
  mps_module mps_module_i (.clock(clock), .reset(reset),
    .link(mps_link_if_i), .module_state(module_state),
    .tx_enable(tx_enable));
  mps_host mps_host_i (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .link(mps_link_if_i));
  mps_link_props mps_link_props_i (.clock(clock), .reset(reset),
    .present(mps_link_if_i.present),
    .hw_low_power_request(mps_link_if_i.hw_low_power_request),
    .module_select(mps_link_if_i.module_select),
    .module_reset(mps_link_if_i.module_reset),
    .int_n(mps_link_if_i.int_n), .req(mps_link_if_i.req),
    .we(mps_link_if_i.we), .addr(mps_link_if_i.addr),
    .wdata(mps_link_if_i.wdata), .rdata(mps_link_if_i.rdata),
    .ack(mps_link_if_i.ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #25 clock = ~clock;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    if (exp_q.size() != 0) n_errors++; // reads never answered
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // one single word transfer; reads note their expectation and mask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [31:0] x, input logic [31:0] m);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    if (!w) exp_q.push_back({m, x & m});
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
  endtask : ahb

  // irq sampled mid-cycle to stay clear of the edge updates
  task wait_irq;
    while (irq !== 1'b1) begin
      @(negedge clock);
      if (module_state === powering_up_state) saw_pu = 1'b1;
    end
  endtask : wait_irq

  // read data taken at the edge that ends the data phase; the slave
  // only moves its data-phase flops after this process has sampled
  always @(posedge clock) begin
    if (dp_rd && hready && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(hrdata & e[63:32], e[31:0]);
      check(32'(hresp), 32'h0000_0000);
    end
    if (hready) dp_rd <= hsel && htrans[1] && !hwrite;
  end

  // hang guard; two passes need a few hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      end_of_test;
    end
  end

  // ----------------------------------------------------------------
  // main sequence: second pass resets mid-run and keeps hw request
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {n_errors, checks_done, cycles} = '0;
    rnd = 32'h90B21729;
    for (run = 0; run < 2; run++) begin
      saw_pu = 1'b0;
      @(posedge clock);
      reset <= 1'b1;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      repeat (9) @(negedge clock);
      check(mps_link_if_i.hw_low_power_request, 1); // held
      check(irq, 0); // quiet in init
      check(32'(module_state), 32'(mgmt_init_state)); // init
      repeat (16) @(negedge clock);
      check(32'(module_state), 32'(low_power_state)); // parked
      check(mps_link_if_i.int_n, 0); // flag raised
      rnd = xs(rnd);
      ahb(1, `MPS_H_IMASK, rnd, 0, 0);
      ahb(0, `MPS_H_IMASK, 0, rnd, 32'h7);
      ahb(0, 32'h20, 0, 0, 32'hFFFFFFFF);
      ahb(1, `MPS_H_IMASK, 32'h1, 0, 0);
      ahb(1, `MPS_H_CTRL, run ? 32'h3 : 32'h1, 0, 0);
      wait_irq;
      ahb(0, `MPS_H_ISTAT, 0, 32'h1, 32'h1);
      ahb(1, `MPS_H_ISTAT, 32'h1, 0, 0);
      ahb(1, `MPS_H_IMASK, 32'h2, 0, 0);
      wait_irq;
      @(negedge clock);
      check(32'(module_state), 32'(ready_state)); // reached
      check(tx_enable, 0); // disable bits hold
      check(saw_pu, 1); // passed through
      ahb(0, `MPS_H_POWER, 0, 32'h5, 32'hFF);
      ahb(0, `MPS_H_ISTAT, 0, 32'h2, 32'h3);
      ahb(1, `MPS_H_ISTAT, 32'h3, 0, 0);
      ahb(0, `MPS_H_ISTAT, 0, 0, 32'h7);
      @(negedge clock);
      check(irq, 0); // cleared
      check(mps_link_if_i.hw_low_power_request, run); // released on first pass, kept on second
    end
    repeat (2) @(negedge clock);
    end_of_test;
  end
endmodule : tb_module_power_up_sequencer
`default_nettype wire
